// File: hw/atc_top.sv
/*
 * Digital control around a 10-bit converter: enable, start, done flag,
 * interrupt request, prescaler, result alignment, auto trigger and
 * digital input buffer disables, reached over classic Wishbone.
 * Assumes the analog core delivers a result when asked to sample, and
 * pin levels arrive asynchronously.
 */
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module atc_top
    import atc_pkg::*;
(
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [6:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Processor side
    input  wire logic        global_irq_en_i,
    input  wire logic        done_vector_ack_i,
    output logic             done_irq_o,
    // Trigger event flags, same clock domain
    input  wire logic        trg_acomp_i,
    input  wire logic        trg_ext0_i,
    input  wire logic        trg_t0_cmpa_i,
    input  wire logic        trg_t0_ovf_i,
    input  wire logic        trg_t1_cmpb_i,
    input  wire logic        trg_t1_ovf_i,
    input  wire logic        trg_t1_capt_i,
    // Analog core
    input  wire logic [9:0]  conv_value_i,
    output logic             conv_tick_o,
    output logic             conv_sample_o,
    // Pins
    input  wire logic [11:0] pin_level_i,
    output logic [11:0]      pin_buffer_off_o,
    output logic [11:0]      pin_in_o
);
    logic [7:0]  csra_r;
    logic [7:0]  csrb_r;
    logic [7:0]  dis_lo_r;
    logic [7:0]  pcr_r;
    logic [9:0]  result_r;
    logic        busy_r;
    logic        first_r;
    logic [4:0]  cyc_cnt_r;
    logic        trig_sel_r;
    logic        ack_r;
    logic [11:0] pin_s1_r;
    logic [11:0] pin_s2_r;
    logic [11:0] pin_s3_r;
    logic [11:0] pin_in_r;
    logic [31:0] rdata_r;

    logic [4:0]  idx;
    logic        wr;
    logic        wr_a;
    logic        wr_b;
    logic        conv_on;
    logic        on_nxt;
    logic        tick;
    logic        trig_sel;
    logic        trig_fire;
    logic        sw_start;
    logic        start;
    logic        finish;
    logic [15:0] result_view;
    logic [4:0]  conv_len;

    function automatic logic sel_flag(input logic [2:0] s,
                                      input logic [7:0] flags);
        sel_flag = flags[s];
    endfunction

    assign idx  = adr_i[6:2];
    assign wr   = cyc_i && stb_i && we_i && !ack_r && sel_i[0];
    assign wr_a = wr && (idx == IDX_CSR_A);
    assign wr_b = wr && (idx == IDX_CSR_B);
    assign conv_on = csra_r[CSRA_ON];
    // Enable as it stands after this edge, so enable and start can share a write
    assign on_nxt  = wr_a ? dat_i[CSRA_ON] : conv_on;

    atc_prescaler u_presc
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (!conv_on),
        .div_sel_i (csra_r[2:0]),
        .tick_o    (tick)
    );

    // Selected event flag; free running watches the done flag
    assign trig_sel = sel_flag(csrb_r[2:0],
        {trg_t1_capt_i, trg_t1_ovf_i, trg_t1_cmpb_i, trg_t0_ovf_i,
         trg_t0_cmpa_i, trg_ext0_i, trg_acomp_i, csra_r[CSRA_DONE]});

    // A rising edge, including one made by reselecting any source but free running, fires the start
    assign trig_fire = csra_r[CSRA_AUTO] && trig_sel && !trig_sel_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trig_sel_r <= 1'b0;
        else if (wr_b && dat_i[2:0] == TRG_FREE)
            trig_sel_r <= 1'b1;
        else
            trig_sel_r <= trig_sel;
    end

    assign sw_start = wr_a && dat_i[CSRA_BEGIN];
    assign start    = on_nxt && !busy_r && (sw_start || trig_fire);
    assign conv_len = first_r ? CONV_FIRST_CYC : CONV_NORMAL_CYC;
    assign finish   = busy_r && tick && (cyc_cnt_r == conv_len - 5'h01);

    // Conversion sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !on_nxt)
        begin
            busy_r    <= 1'b0;
            cyc_cnt_r <= 5'h00;
        end
        else if (start)
        begin
            busy_r    <= 1'b1;
            cyc_cnt_r <= 5'h00;
        end
        else if (finish)
            busy_r    <= 1'b0;
        else if (busy_r && tick)
            cyc_cnt_r <= cyc_cnt_r + 5'h01;
    end

    // The long first conversion follows every enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !conv_on)
            first_r <= 1'b1;
        else if (finish)
            first_r <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            result_r <= 10'h000;
        else if (finish)
            result_r <= conv_value_i;
    end

    // Control A; hardware set of the done flag wins over any clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            csra_r <= RST_CSR_A;
        else
        begin
            if (wr_a)
            begin
                csra_r[CSRA_ON]   <= dat_i[CSRA_ON];
                csra_r[CSRA_AUTO] <= dat_i[CSRA_AUTO];
                csra_r[CSRA_IE]   <= dat_i[CSRA_IE];
                csra_r[2:0]       <= dat_i[2:0];
            end
            if (finish)
                csra_r[CSRA_DONE] <= 1'b1;
            else if (done_vector_ack_i)
                csra_r[CSRA_DONE] <= 1'b0;
            else if (wr_a && dat_i[CSRA_DONE])
                csra_r[CSRA_DONE] <= 1'b0;
            csra_r[CSRA_BEGIN] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            csrb_r <= RST_CSR_B;
        else if (wr_b)
            csrb_r <= {dat_i[7:6], 2'b00, dat_i[3:0]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dis_lo_r <= RST_DIS_LO;
        else if (wr && idx == IDX_DIS_LO)
            dis_lo_r <= dat_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pcr_r <= RST_PCR;
        else if (wr && idx == IDX_PORT_CTRL_HI)
            pcr_r <= {dat_i[7:4], 1'b0, dat_i[2:0]};
    end

    assign pin_buffer_off_o = {pcr_r[7:PCR_PIN_HI_LSB], dis_lo_r};

    // Pins are asynchronous: change accepted when stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_r <= 12'h000;
            pin_s2_r <= 12'h000;
            pin_s3_r <= 12'h000;
            pin_in_r <= 12'h000;
        end
        else
        begin
            pin_s1_r <= pin_level_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_in_r <= ((pin_s2_r & pin_s3_r)
                         | (pin_in_r & (pin_s2_r | pin_s3_r)))
                        & ~pin_buffer_off_o;
        end
    end
    assign pin_in_o = pin_in_r;

    // Alignment is applied on read, so it tracks the bit immediately
    assign result_view = csrb_r[CSRB_ALIGN] ? {result_r, 6'h00}
                                            : {6'h00, result_r};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_r <= 32'h0000_0000;
        else
        begin
            case (idx)
                IDX_CSR_A:        rdata_r <= {24'h000000, csra_r[7],
                                              busy_r, csra_r[5:0]};
                IDX_CSR_B:        rdata_r <= {24'h000000, csrb_r};
                IDX_DIS_LO:       rdata_r <= {24'h000000, dis_lo_r};
                IDX_PORT_CTRL_HI: rdata_r <= {24'h000000, pcr_r};
                IDX_RESULT_LO:    rdata_r <= {24'h000000, result_view[7:0]};
                IDX_RESULT_HI:    rdata_r <= {24'h000000, result_view[15:8]};
                default:          rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= cyc_i && stb_i && !ack_r;
    end

    assign ack_o         = ack_r;
    assign dat_o         = rdata_r;
    assign done_irq_o    = csra_r[CSRA_DONE] && csra_r[CSRA_IE]
                           && global_irq_en_i;
    assign conv_tick_o   = tick;
    assign conv_sample_o = finish;
endmodule // atc_top
`default_nettype wire

// File: common/atc_pkg.sv
/*
 * Package for the converter trigger and flag control block: register
 * offsets, field positions, reset values and trigger source codes.
 * Assumes a 32-bit classic Wishbone slave with one register per word.
 */
package atc_pkg;
    // Printed offsets are register indices; byte address is index times 4
    localparam logic [4:0] IDX_PORT_CTRL_HI = 5'h08;
    localparam logic [4:0] IDX_DIS_LO       = 5'h0D;
    localparam logic [4:0] IDX_RESULT_LO    = 5'h0E;
    localparam logic [4:0] IDX_RESULT_HI    = 5'h0F;
    localparam logic [4:0] IDX_CSR_B        = 5'h11;
    localparam logic [4:0] IDX_CSR_A        = 5'h12;

    // Control and status A fields
    localparam int CSRA_ON    = 7;
    localparam int CSRA_BEGIN = 6;
    localparam int CSRA_AUTO  = 5;
    localparam int CSRA_DONE  = 4;
    localparam int CSRA_IE    = 3;
    // Control and status B fields
    localparam int CSRB_TOUCH_A = 7;
    localparam int CSRB_TOUCH_B = 6;
    localparam int CSRB_ALIGN   = 3;
    // Port control fields
    localparam int PCR_PIN_HI_LSB = 4;
    localparam int PCR_BBM_MASK   = 3'h7;

    localparam logic [7:0] RST_CSR_A   = 8'h00;
    localparam logic [7:0] RST_CSR_B   = 8'h00;
    localparam logic [7:0] RST_DIS_LO  = 8'h00;
    localparam logic [7:0] RST_PCR     = 8'h00;

    // Conversion length in converter clock cycles
    localparam logic [4:0] CONV_FIRST_CYC  = 5'h19;
    localparam logic [4:0] CONV_NORMAL_CYC = 5'h0D;

    typedef enum logic [2:0] {
        TRG_FREE, TRG_ACOMP, TRG_EXT0, TRG_T0_CMPA,
        TRG_T0_OVF, TRG_T1_CMPB, TRG_T1_OVF, TRG_T1_CAPT
    } atc_trig_e;
endpackage

// File: hw/atc_prescaler.sv
/*
 * Converter clock prescaler: free-running counter producing a one-cycle
 * enable every 2 to 128 system clocks.
 * Assumes the caller holds it in clear while the converter is off.
 */
`timescale 1ns/10ps
`default_nettype none
module atc_prescaler
(
    // System
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       clear_i,
    input  wire logic [2:0] div_sel_i,
    // Converter clock enable
    output logic            tick_o
);
    logic [6:0] cnt_r;
    logic [6:0] mask;

    // 000 and 001 both divide by 2
    always_comb
    begin
        case (div_sel_i)
            3'h0, 3'h1: mask = 7'h01;
            3'h2:       mask = 7'h03;
            3'h3:       mask = 7'h07;
            3'h4:       mask = 7'h0F;
            3'h5:       mask = 7'h1F;
            3'h6:       mask = 7'h3F;
            default:    mask = 7'h7F;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
            cnt_r <= 7'h00;
        else
            cnt_r <= cnt_r + 7'h01;
    end

    assign tick_o = !clear_i && ((cnt_r & mask) == mask);
endmodule // atc_prescaler
`default_nettype wire

// File: sim/atc_checker.sv
/*
 * Port checker for atc_top: bus handshake, flags, prescaler, pins.
 * Assumes it is bound to atc_top and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module atc_checker
    import atc_pkg::*;
(
    // System and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [6:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Processor, converter and pins
    input wire logic        global_irq_en_i,
    input wire logic        done_vector_ack_i,
    input wire logic        done_irq_o,
    input wire logic        conv_tick_o,
    input wire logic        conv_sample_o,
    input wire logic [11:0] pin_buffer_off_o,
    input wire logic [11:0] pin_in_o
);
    logic on_r;

    // Mirror of the enable bit, taken on the same edge as the design
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            on_r <= 1'b0;
        else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                 && adr_i[6:2] == IDX_CSR_A)
            on_r <= dat_i[CSRA_ON];
    end

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("acknowledge wider than one cycle");
    a_csrb_zero: assert property (ack_o && !we_i
        && adr_i[6:2] == IDX_CSR_B |-> dat_o[5:4] == 2'h0)
        else $error("reserved control bits read one");
    a_irq_global: assert property (done_irq_o |-> global_irq_en_i)
        else $error("interrupt without global enable");
    a_tick_off: assert property (!on_r [*2] |-> !conv_tick_o)
        else $error("converter clock while off");
    a_tick_pulse: assert property (conv_tick_o |=> !conv_tick_o)
        else $error("converter clock enable wider than one cycle");
    a_sample_on: assert property (conv_sample_o |-> on_r)
        else $error("conversion finished while off");
    a_pin_zero: assert property
        (($past(pin_buffer_off_o) & pin_buffer_off_o & pin_in_o) == 12'h000)
        else $error("disabled pin reads one");
    a_vector_clear: assert property (done_vector_ack_i
        && !conv_sample_o && !$past(conv_sample_o) |=> !done_irq_o)
        else $error("vector left the done flag set");
endmodule // atc_checker

bind atc_top atc_checker u_atc_checker (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .global_irq_en_i,
    .done_vector_ack_i, .done_irq_o, .conv_tick_o, .conv_sample_o,
    .pin_buffer_off_o, .pin_in_o);
`default_nettype wire

// File: sim/atc_top_tb.sv
/*
 * Self-checking bench for atc_top: registers, pins, prescaler,
 * conversions, alignment, done flag and auto trigger.
 * Assumes the checker is bound beside the design.
 */
`timescale 1ns/10ps
`default_nettype none
module atc_top_tb;
    import atc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        global_irq_en_i = 1, done_vector_ack_i = 0;
    logic [6:0]  adr_i = 0, trg = 0;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 0, dat_o, seed = 32'hAF79;
    logic [9:0]  conv_value_i = 0;
    logic [11:0] pin_level_i = 0, pin_buffer_off_o, pin_in_o;
    logic        ack_o, done_irq_o, conv_tick_o, conv_sample_o;
    logic [7:0]  q, dis;
    int          fails = 0, cmp_count = 0, ns, nt, n1, k;

    always #20 clk_i = ~clk_i;

    atc_top u_atc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .global_irq_en_i,
        .done_vector_ack_i, .done_irq_o, .trg_acomp_i(trg[0]),
        .trg_ext0_i(trg[1]), .trg_t0_cmpa_i(trg[2]), .trg_t0_ovf_i(trg[3]),
        .trg_t1_cmpb_i(trg[4]), .trg_t1_ovf_i(trg[5]),
        .trg_t1_capt_i(trg[6]), .conv_value_i, .conv_tick_o,
        .conv_sample_o, .pin_level_i, .pin_buffer_off_o, .pin_in_o);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic cycle; read data lands in q at the acknowledge edge
    task automatic wb(input logic w, input logic [4:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {i, 2'h0};
        dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
        begin
            fails++;
            tally_and_finish();
        end
    endtask

    // Stops at the first finish so the next start keeps the tick phase
    task automatic run;
        int c;
        c = 0;
        ns = 0;
        nt = 0;
        while (ns == 0 && c < 4000)
        begin
            @(posedge clk_i);
            c++;
            nt += (conv_tick_o === 1'b1);
            ns += (conv_sample_o === 1'b1);
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 32; k++)
        begin
            wb(0, k[4:0], 8'h00);
            chk("reset", q, 8'h00);
        end
        dis = 8'($random(seed));
        wb(1, IDX_DIS_LO, dis);
        wb(1, IDX_PORT_CTRL_HI, 8'h5F);
        wb(0, IDX_PORT_CTRL_HI, 8'h00);
        chk("port_ctrl", q, 8'h57);
        pin_level_i <= 12'($random(seed));
        repeat (6) @(posedge clk_i);
        chk("buf_off", pin_buffer_off_o, {4'h5, dis});
        chk("pin_in", pin_in_o, pin_level_i & ~{4'h5, dis});
        for (k = 0; k < 8; k++)
        begin
            wb(1, IDX_CSR_A, 8'h00);
            wb(1, IDX_CSR_A, 8'h80 | k[7:0]);
            n1 = 0;
            nt = 0;
            while (nt < 2 && n1 < 400)
            begin
                @(posedge clk_i);
                n1++;
                if (conv_tick_o === 1'b1)
                begin
                    nt++;
                    ns = (nt == 1) ? n1 : n1 - ns;
                end
            end
            chk("divide", ns, (k < 2) ? 2 : 1 << k);
        end
        conv_value_i <= 10'($random(seed));
        wb(1, IDX_CSR_A, 8'h00);
        wb(1, IDX_CSR_A, 8'hCF);
        wb(0, IDX_CSR_A, 8'h00);
        chk("busy", q[6], 1'b1);
        run();
        n1 = nt;
        chk("finish", ns, 1);
        wb(0, IDX_CSR_A, 8'h00);
        chk("csr_a", q, 8'h9F);
        chk("irq", done_irq_o, 1'b1);
        global_irq_en_i <= 1'b0;
        @(posedge clk_i);
        chk("irq_gated", done_irq_o, 1'b0);
        global_irq_en_i <= 1'b1;
        wb(0, IDX_RESULT_LO, 8'h00);
        chk("res_lo", q, conv_value_i[7:0]);
        wb(0, IDX_RESULT_HI, 8'h00);
        chk("res_hi", q, {6'h0, conv_value_i[9:8]});
        wb(1, IDX_CSR_A, 8'hCF);
        wb(0, IDX_CSR_A, 8'h00);
        chk("busy", q[6], 1'b1);
        run();
        chk("first_extra", n1 - nt, 12);
        wb(1, IDX_CSR_A, 8'hCF);
        wb(1, IDX_CSR_B, 8'h08);
        wb(0, IDX_RESULT_HI, 8'h00);
        chk("left_hi", q, conv_value_i[9:2]);
        wb(0, IDX_RESULT_LO, 8'h00);
        chk("left_lo", q, {conv_value_i[1:0], 6'h0});
        run();
        wb(1, IDX_CSR_A, 8'h8F);
        wb(0, IDX_CSR_A, 8'h00);
        chk("keep_done", q, 8'h9F);
        wb(1, IDX_CSR_A, 8'h9F);
        wb(0, IDX_CSR_A, 8'h00);
        chk("clear_done", q, 8'h8F);
        wb(1, IDX_CSR_A, 8'hCF);
        run();
        @(posedge clk_i);
        done_vector_ack_i <= 1'b1;
        @(posedge clk_i);
        done_vector_ack_i <= 1'b0;
        wb(0, IDX_CSR_A, 8'h00);
        chk("vector", q, 8'h8F);
        wb(1, IDX_CSR_A, 8'hCF);
        wb(1, IDX_CSR_A, 8'h00);
        run();
        chk("abort", ns, 0);
        // Ones in the reserved pair must not read back
        wb(1, IDX_CSR_B, 8'h31);
        wb(0, IDX_CSR_B, 8'h00);
        chk("csr_b", q, 8'h01);
        wb(1, IDX_CSR_A, 8'h8F);
        trg <= 7'h01;
        run();
        chk("no_auto", ns, 0);
        trg <= 7'h00;
        wb(1, IDX_CSR_A, 8'hAF);
        for (k = 1; k < 8; k++)
        begin
            wb(1, IDX_CSR_B, k[7:0]);
            trg <= 7'(1 << (k - 1));
            run();
            chk("trigger", ns, 1);
            trg <= 7'h00;
        end
        wb(1, IDX_CSR_B, 8'h01);
        trg <= 7'h02;
        run();
        chk("other_src", ns, 0);
        wb(1, IDX_CSR_B, 8'h02);
        run();
        chk("switch_edge", ns, 1);
        wb(1, IDX_CSR_B, 8'h00);
        run();
        chk("free_select", ns, 0);
        // Clear done and start: free running must retrigger on the new flag
        wb(1, IDX_CSR_A, 8'hFF);
        run();
        chk("free_first", ns, 1);
        run();
        chk("free_run", ns, 1);
        tally_and_finish();
    end
endmodule // atc_top_tb
`default_nettype wire
